// ==== verilog/supervisor_map.svh ====
// register offsets, field positions, reset values and timing figures
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH
`define OFS_CTRL 5'h00
`define OFS_STATE 5'h04
`define OFS_IRQ_STS 5'h08
`define OFS_IRQ_EN 5'h0c
`define OFS_IRQ_CLR 5'h10
`define CTRL_TIMEOUT_OPTION_SELECT_LSB 0
`define CTRL_MANUAL_BIT 2
`define TIMEOUT_OPTION_SELECT_DEFAULT 2'h2
`define MANUAL_RESET 1'h0
`define IRQ_SUPPLY_BIT 0
`define IRQ_WDOG_BIT 1
`define IRQ_PFAIL_BIT 2
`define IRQ_RELEASE_BIT 3
`define IRQ_EN_RESET 4'h0
`define IRQ_STS_RESET 4'h0
`define CLK_HZ 40000000
`define HOLD_T1_MS 50
`define HOLD_T2_MS 100
`define HOLD_T3_MS 200
`define HOLD_T4_MS 400
`define WDOG_MS 1600
`endif

// ==== verilog/supervisor_pkg.sv ====
// types shared by the reset supervisor
package supervisor_pkg;
	typedef enum logic [1:0] {
		st_low = 2'b00,
		st_hold = 2'b01,
		st_run = 2'b10
	} state_t;
	typedef logic [26:0] cnt_t;
endpackage

// ==== verilog/reset_supervisor.sv ====
// digital control of a triple-supply reset supervisor with watchdog
// Function
// [RULE1] any supply below its threshold asserts the reset output
// [RULE2] reset held one full timeout after all supplies good; new fault restarts it
// [RULE3] hold time selectable among 50, 100, 200 and 400 ms
// [RULE4] hold time defaults to 200 ms
// [RULE5] no kick edge for the watchdog period gives overflow and reset
// [RULE6] each overflow pulses reset active for exactly one hold period
// [RULE7] watchdog count clears on reset, manual reset or any kick edge
// [RULE8] kick input left open services the watchdog, no overflow ever
// [RULE9] host must toggle the kick input faster than the watchdog period
// [RULE10] power-fail flag low exactly while the sense comparator shows low
// [RULE11] reset output polarity is a build option, active low or high
// [RULE12] inputs pass two-flop synchronisers; all timing from the clock
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "supervisor_map.svh"
module reset_supervisor
	import supervisor_pkg::*;
#(
	parameter bit ACTIVE_HIGH = 1'b0,
	parameter int HOLD_T1_CYC = `HOLD_T1_MS * (`CLK_HZ / 1000),
	parameter int HOLD_T2_CYC = `HOLD_T2_MS * (`CLK_HZ / 1000),
	parameter int HOLD_T3_CYC = `HOLD_T3_MS * (`CLK_HZ / 1000),
	parameter int HOLD_T4_CYC = `HOLD_T4_MS * (`CLK_HZ / 1000),
	parameter int WDOG_CYC = `WDOG_MS * (`CLK_HZ / 1000)
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	input wire logic clock_enable,
	// comparator flags, high when below threshold
	input wire logic supply_one_monitor,
	input wire logic supply_two_monitor,
	input wire logic supply_three_monitor,
	input wire logic power_fail_sense_input,
	// watchdog kick and its open-pin detect
	input wire logic watchdog_kick_input,
	input wire logic watchdog_kick_open,
	// outputs to the host
	output logic supervisor_reset_output,
	output logic power_fail_flag_n,
	output logic irq,
	// avalon-mm slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest
);

	// ==========================================================
	// hold time decode
	function automatic cnt_t hold_limit(input logic [1:0] sel);
		unique case (sel)
			2'h0: hold_limit = cnt_t'(HOLD_T1_CYC);
			2'h1: hold_limit = cnt_t'(HOLD_T2_CYC);
			2'h2: hold_limit = cnt_t'(HOLD_T3_CYC);
			2'h3: hold_limit = cnt_t'(HOLD_T4_CYC);
		endcase
	endfunction

	// ==========================================================
	// input synchronisers
	// two flops per pin; only the second one feeds the logic
	wire logic [5:0] raw_w = {watchdog_kick_open, watchdog_kick_input,
		power_fail_sense_input, supply_three_monitor,
		supply_two_monitor, supply_one_monitor};
	logic [5:0] meta_r;
	logic [5:0] sync_r;
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			always_ff @(posedge clock) begin
				if (!rstn) begin
					meta_r[gi] <= 1'h0;
					sync_r[gi] <= 1'h0;
				end else if (clock_enable) begin
					meta_r[gi] <= raw_w[gi]; // [RULE12]
					sync_r[gi] <= meta_r[gi]; // [RULE12]
				end
			end
		end
	endgenerate
	wire logic [2:0] sup_s = sync_r[2:0];
	wire logic pf_s = sync_r[3];
	wire logic kick_s = sync_r[4];
	wire logic open_s = sync_r[5];

	// ==========================================================
	// registers and state
	state_t state_r;
	state_t state_nxt;
	cnt_t hold_cnt_r;
	cnt_t hold_cnt_nxt;
	cnt_t wd_cnt_r;
	cnt_t wd_cnt_nxt;
	logic kick_prev_r;
	logic [1:0] timeout_option_select_r;
	logic manual_r;
	logic [3:0] sts_r;
	logic [3:0] sts_nxt;
	logic [3:0] en_r;
	logic ack_r;
	logic rst_lvl_nxt;

	// ==========================================================
	// bus decode
	wire logic wr_fire = write & ack_r & byteenable[0];
	wire logic wr_ctrl = wr_fire & (address == `OFS_CTRL);
	wire logic wr_en = wr_fire & (address == `OFS_IRQ_EN);
	wire logic wr_clr = wr_fire & (address == `OFS_IRQ_CLR);
	wire logic [3:0] clr_mask = wr_clr ? writedata[3:0] : 4'h0;
	wire logic [31:0] rd_mux =
		(address == `OFS_CTRL) ? {29'h0, manual_r, timeout_option_select_r} :
		(address == `OFS_STATE) ? {25'h0, state_r, sup_s, pf_s, state_r != st_run} :
		(address == `OFS_IRQ_STS) ? {28'h0, sts_r} :
		(address == `OFS_IRQ_EN) ? {28'h0, en_r} : 32'h0;
	// an answer only counts on an enabled edge, so a frozen cycle keeps the master waiting
	assign waitrequest = (read | write) & ~(ack_r & clock_enable);

	// ==========================================================
	// supervisor decisions
	wire logic fail_w = (|sup_s) | manual_r; // [RULE1]
	wire cnt_t hold_lim_w = hold_limit(timeout_option_select_r); // [RULE3]
	wire logic hold_done_w = hold_cnt_r == hold_lim_w - cnt_t'(1);
	wire logic kick_edge_w = kick_s ^ kick_prev_r;
	// host toggling keeps the count below its end
	wire logic wd_clear_w = (state_r != st_run) | manual_r
		| kick_edge_w | open_s; // [RULE7] [RULE8] [RULE9]
	wire logic wd_done_w = wd_cnt_r == cnt_t'(WDOG_CYC) - cnt_t'(1);
	wire logic wd_ovf_w = (state_r == st_run) & ~wd_clear_w & wd_done_w; // [RULE5]
	// sticky events; a set in the same cycle beats a clear
	wire logic [3:0] ev_w = {
		(state_r == st_hold) & hold_done_w & ~fail_w,
		pf_s & power_fail_flag_n,
		wd_ovf_w & ~fail_w,
		fail_w & (state_r != st_low)};

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			st_low: begin
				if (!fail_w) begin
					state_nxt = st_hold; // [RULE2]
				end
			end
			st_hold: begin
				if (fail_w) begin
					state_nxt = st_low; // [RULE2]
				end else if (hold_done_w) begin
					state_nxt = st_run; // [RULE2]
				end
			end
			st_run: begin
				if (fail_w) begin
					state_nxt = st_low; // [RULE1]
				end else if (wd_ovf_w) begin
					state_nxt = st_hold; // [RULE6]
				end
			end
			default: state_nxt = st_low;
		endcase
	end

	always_comb begin
		hold_cnt_nxt = cnt_t'(0);
		if ((state_r == st_hold) && !fail_w && !hold_done_w) begin
			hold_cnt_nxt = hold_cnt_r + cnt_t'(1); // [RULE2]
		end
		wd_cnt_nxt = wd_clear_w ? cnt_t'(0) : wd_cnt_r + cnt_t'(1); // [RULE7]
		sts_nxt = (sts_r & ~clr_mask) | ev_w;
		rst_lvl_nxt = (state_nxt != st_run) ~^ ACTIVE_HIGH; // [RULE11]
	end

	// ==========================================================
	// state flops
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_r <= st_low;
			hold_cnt_r <= cnt_t'(0);
			wd_cnt_r <= cnt_t'(0);
			kick_prev_r <= 1'h0;
		end else if (clock_enable) begin
			state_r <= state_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			kick_prev_r <= kick_s;
		end
	end

	// output flops
	always_ff @(posedge clock) begin
		if (!rstn) begin
			supervisor_reset_output <= ACTIVE_HIGH; // [RULE11]
			power_fail_flag_n <= 1'h1;
			irq <= 1'h0;
		end else if (clock_enable) begin
			supervisor_reset_output <= rst_lvl_nxt; // [RULE6]
			power_fail_flag_n <= ~pf_s; // [RULE10]
			irq <= |(sts_nxt & en_r);
		end
	end

	// register file flops
	always_ff @(posedge clock) begin
		if (!rstn) begin
			timeout_option_select_r <= `TIMEOUT_OPTION_SELECT_DEFAULT; // [RULE4]
			manual_r <= `MANUAL_RESET;
			en_r <= `IRQ_EN_RESET;
			sts_r <= `IRQ_STS_RESET;
			ack_r <= 1'h0;
			readdata <= 32'h0;
		end else if (clock_enable) begin
			ack_r <= (read | write) & ~ack_r;
			if (read & ~ack_r) begin
				readdata <= rd_mux;
			end
			if (wr_ctrl) begin
				timeout_option_select_r <= writedata[`CTRL_TIMEOUT_OPTION_SELECT_LSB +: 2]; // [RULE3]
				manual_r <= writedata[`CTRL_MANUAL_BIT];
			end
			if (wr_en) begin
				en_r <= writedata[3:0];
			end
			sts_r <= sts_nxt;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	wire logic active_w = supervisor_reset_output == ACTIVE_HIGH;

	sequence s_low_held;
		(supply_one_monitor && clock_enable) [*3];
	endsequence
	sequence s_ovf;
		clock_enable && wd_ovf_w && !fail_w;
	endsequence

	chk_supply_asserts: assert property ( // [RULE1] [RULE12]
		s_low_held |=> active_w && state_r == st_low)
		else $error("reset not asserted on low supply");
	chk_release_time: assert property ( // [RULE2]
		clock_enable && state_r == st_run && $past(state_r) == st_hold
		|-> $past(hold_cnt_r) == $past(hold_lim_w) - cnt_t'(1))
		else $error("reset released before full hold");
	chk_hold_restart: assert property ( // [RULE2]
		clock_enable && fail_w |=> hold_cnt_r == cnt_t'(0) && active_w)
		else $error("hold not restarted by fault");
	chk_hold_select: assert property ( // [RULE3]
		hold_lim_w == ((timeout_option_select_r == 2'h0) ? cnt_t'(HOLD_T1_CYC) :
		(timeout_option_select_r == 2'h1) ? cnt_t'(HOLD_T2_CYC) :
		(timeout_option_select_r == 2'h2) ? cnt_t'(HOLD_T3_CYC) : cnt_t'(HOLD_T4_CYC)))
		else $error("hold limit decode wrong");
	chk_default_hold: assert property (disable iff (1'b0) // [RULE4]
		!rstn |=> timeout_option_select_r == `TIMEOUT_OPTION_SELECT_DEFAULT)
		else $error("default hold not 200 ms");
	chk_wdog_overflow: assert property ( // [RULE5] [RULE6]
		s_ovf |=> state_r == st_hold && active_w && sts_r[`IRQ_WDOG_BIT])
		else $error("watchdog overflow not acted on");
	chk_wdog_clear: assert property ( // [RULE7]
		clock_enable && (kick_edge_w || manual_r || state_r != st_run)
		|=> wd_cnt_r == cnt_t'(0))
		else $error("watchdog count not cleared");
	chk_open_no_ovf: assert property ( // [RULE8]
		clock_enable && open_s |-> !wd_ovf_w ##1 wd_cnt_r == cnt_t'(0))
		else $error("watchdog ran with kick input open");
	chk_pfail_follow: assert property ( // [RULE10]
		clock_enable && $stable(pf_s) |=> power_fail_flag_n == !$past(pf_s))
		else $error("power-fail flag does not follow comparator");
	chk_out_polarity: assert property ( // [RULE11] [RULE6]
		clock_enable && state_nxt == st_run |=> !active_w)
		else $error("reset output level wrong for polarity");

	// ==========================================================
	// freeze, release, bus and interrupt checks
	sequence s_hold_end;
		clock_enable && state_r == st_hold && hold_done_w && !fail_w;
	endsequence

	chk_release_event: assert property ( // [RULE2]
		s_hold_end |=> state_r == st_run && !active_w && sts_r[`IRQ_RELEASE_BIT])
		else $error("release after hold not reported");
	chk_pfail_onset: assert property ( // [RULE10]
		clock_enable && pf_s && power_fail_flag_n |=> !power_fail_flag_n
		&& sts_r[`IRQ_PFAIL_BIT])
		else $error("power-fail onset not flagged");
	chk_freeze_state: assert property (
		!clock_enable |=> $stable(state_r) && $stable(hold_cnt_r) && $stable(wd_cnt_r)
		&& $stable(supervisor_reset_output) && $stable(sts_r))
		else $error("state moved while clock enable low");
	chk_bus_answer: assert property (
		clock_enable && (read || write) && !ack_r |=> ack_r)
		else $error("bus request not answered");
	chk_bus_release: assert property (
		clock_enable && ack_r |=> !ack_r)
		else $error("bus answer held too long");
	chk_irq_level: assert property (
		clock_enable && (sts_r & en_r) != 4'h0 && !wr_clr |=> irq)
		else $error("interrupt low with enabled status set");

endmodule

// ==== verification/host_kicker.sv ====
// host-side partner that services the watchdog kick pin
`timescale 1ns/1ps
module host_kicker (
	// clock
	input wire logic clock,
	// kick enable from the bench
	input wire logic kicking,
	// kick pin
	output logic kick
);
	// ==========================================
	// kick generator
	integer seed = 32'h5fe6;
	integer gap = 0;
	initial kick = 1'b0;
	always @(posedge clock) begin
		if (gap > 0) begin
			gap <= gap - 1;
		end else if (kicking) begin
			kick <= ~kick;
			gap <= 20 + ($random(seed) & 63);
		end
	end
endmodule

// ==== verification/reset_supervisor_test.sv ====
// self-checking bench for the reset supervisor
`timescale 1ns/1ps
`include "supervisor_map.svh"
module reset_supervisor_test;
	import supervisor_pkg::*;
	logic clock = 0, rstn = 0, supply_one_monitor = 1, supply_two_monitor = 0;
	logic supply_three_monitor = 0, power_fail_sense_input = 0, watchdog_kick_open = 0;
	logic read = 0, write = 0, kicking = 1, clock_enable = 1;
	logic [4:0] address = 5'h00;
	logic [3:0] be = 4'hf;
	logic [31:0] writedata = 32'h0, rd, readdata;
	logic watchdog_kick_input, supervisor_reset_output, power_fail_flag_n, irq, waitrequest;
	integer failures = 0, n_compared = 0, seed = 32'h5fe6, n, sel, opt, bad;
	int hold_cyc[4] = '{20, 40, 80, 160};
	reset_supervisor #(.HOLD_T1_CYC(20), .HOLD_T2_CYC(40), .HOLD_T3_CYC(80),
		.HOLD_T4_CYC(160), .WDOG_CYC(300)) reset_supervisor_i (
		.clock(clock), .rstn(rstn), .clock_enable(clock_enable),
		.supply_one_monitor(supply_one_monitor), .supply_two_monitor(supply_two_monitor),
		.supply_three_monitor(supply_three_monitor),
		.power_fail_sense_input(power_fail_sense_input),
		.watchdog_kick_input(watchdog_kick_input), .watchdog_kick_open(watchdog_kick_open),
		.supervisor_reset_output(supervisor_reset_output),
		.power_fail_flag_n(power_fail_flag_n), .irq(irq), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(be),
		.readdata(readdata), .waitrequest(waitrequest));
	host_kicker host_kicker_i (.clock(clock), .kicking(kicking), .kick(watchdog_kick_input));
	// ==========================================
	// tasks
	task give_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		read <= ~w;
		write <= w;
		address <= a;
		writedata <= d;
		do @(posedge clock); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wait_out(input logic lvl, input int lim);
		n = 0;
		while (supervisor_reset_output !== lvl && n < lim) begin
			@(negedge clock);
			n++;
		end
	endtask
	task sup(input int s, input logic v);
		@(posedge clock);
		case (s)
			0: supply_one_monitor <= v;
			1: supply_two_monitor <= v;
			default: supply_three_monitor <= v;
		endcase
	endtask
	// ==========================================
	// stimulus
	initial begin
		forever #12.5 clock = ~clock;
	end
	initial begin
		repeat (30000) @(posedge clock);
		failures++;
		give_verdict;
	end
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		acc(0, `OFS_CTRL, 0);
		chk("reset at power-up", 0, supervisor_reset_output);
		chk("default hold", 2, rd);
		acc(0, 5'h1c, 0);
		chk("unmapped read", 0, rd);
		acc(1, `OFS_IRQ_EN, 32'hf);
		sup(0, 0);
		wait_out(1, 200);
		for (opt = 0; opt < 4; opt++) begin
			acc(1, `OFS_CTRL, opt);
			sel = {$random(seed)} % 3;
			sup(sel, 1);
			wait_out(0, 10);
			chk("fault to reset", 1, n < 10);
			sup(sel, 0);
			repeat (hold_cyc[opt] / 2) @(posedge clock);
			sup(sel, 1);
			sup(sel, 0);
			wait_out(1, 400);
			chk("hold length", 1, n >= hold_cyc[opt] && n <= hold_cyc[opt] + 6);
			$display("hold option %0d done", opt);
		end
		chk("irq raised", 1, irq);
		acc(0, `OFS_IRQ_STS, 0);
		chk("irq status", 32'h9, rd);
		acc(1, `OFS_IRQ_CLR, 32'hf);
		repeat (2) @(posedge clock);
		chk("irq cleared", 0, irq);
		kicking <= 1'b0;
		wait_out(0, 400);
		chk("watchdog overflow", 1, n >= 200 && n <= 310);
		kicking <= 1'b1;
		wait_out(1, 400);
		chk("overflow pulse", 1, n >= 158 && n <= 166);
		acc(0, `OFS_IRQ_STS, 0);
		chk("overflow status", 1, rd[1]);
		$display("watchdog test done");
		acc(1, `OFS_CTRL, 32'h7);
		wait_out(0, 10);
		chk("manual reset", 1, n < 10);
		acc(1, `OFS_CTRL, 32'h3);
		be <= 4'he;
		acc(1, `OFS_CTRL, 32'h4);
		be <= 4'hf;
		acc(0, `OFS_CTRL, 0);
		chk("masked write ignored", 3, rd);
		wait_out(1, 400);
		@(posedge clock);
		kicking <= 1'b0;
		watchdog_kick_open <= 1'b1;
		bad = 0;
		repeat (900) begin
			@(negedge clock);
			if (supervisor_reset_output !== 1'b1) bad++;
		end
		chk("open kick pin", 0, bad);
		$display("manual and open pin test done");
		@(posedge clock);
		power_fail_sense_input <= 1'b1;
		repeat (5) @(negedge clock);
		chk("power fail low", 0, power_fail_flag_n);
		chk("reset unaffected", 1, supervisor_reset_output);
		acc(0, `OFS_STATE, 0);
		chk("state register", 32'h42, rd);
		@(posedge clock);
		power_fail_sense_input <= 1'b0;
		repeat (5) @(negedge clock);
		chk("power fail high", 1, power_fail_flag_n);
		@(posedge clock);
		clock_enable <= 1'b0;
		power_fail_sense_input <= 1'b1;
		repeat (8) @(negedge clock);
		chk("frozen flag", 1, power_fail_flag_n);
		@(posedge clock);
		clock_enable <= 1'b1;
		repeat (5) @(negedge clock);
		chk("flag after freeze", 0, power_fail_flag_n);
		acc(0, `OFS_IRQ_STS, 0);
		chk("power fail status", 1, rd[2]);
		$display("power fail test done");
		give_verdict;
	end
endmodule
